//--- verilog/adc_standby_ctl.sv
// Pin controls, standby sequencing, register port and link serialiser of the octal converter.
`timescale 1ns/1ns

// Notes on behaviour
// - With pattern test select high every channel sends the fixed word 0000 1011 1101.
// - With pattern test select low and the control pattern bit clear every channel sends normal conversion results.
// - Standby select high puts all conversion channels into low power through one shared input.
// - The reference stays powered and active during standby.
// - During standby each channel's analog input pair is cut off from its input amplifier.
// - Standby is left only on a high-to-low transition of standby select.
// - After leaving standby the data is flagged invalid for the 200 us settle time.
// - Double-termination select high connects the 100 ohm output resistor, low disconnects it.
// - Words go out LSB first, bits changing on both edges of a bit clock at six times the sample rate.
// - The frame output runs at the sample rate and rises with the first bit of each word.
// - A result appears on the outputs 6.5 sample periods after its sample edge.
// - Format select low gives two's complement, high gives offset binary with midscale 0x800.
module adc_standby_ctl
  import adc_ctl_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYCLES_DEF
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic link_clk_i,
  input wire logic pattern_test_select_i,
  input wire logic standby_select_i,
  input wire logic output_double_term_select_i,
  input wire logic format_select_i,
  input wire conv_bus_t conv_data_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic [NUM_CH-1:0] serial_data_pos_o,
  output logic [NUM_CH-1:0] serial_data_neg_o,
  output logic frame_align_out_pos_o,
  output logic frame_align_out_neg_o,
  output logic serial_bit_clock_pos_o,
  output logic serial_bit_clock_neg_o,
  output logic channel_power_down_o,
  output logic input_disconnect_o,
  output logic ref_active_o,
  output logic term_enable_o,
  output logic data_valid_o
);

  localparam logic [WAKE_CNT_W-1:0] WAKE_LOAD = WAKE_CNT_W'(WAKE_CYCLES - 1);
  localparam logic [WAKE_CNT_W-1:0] WAKE_ZERO = '0;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_t pin_raw_w;
  pin_t pin_s;
  logic standby_select_prev_q;
  logic standby_select_fall_w;

  assign pin_raw_w = '{pattern: pattern_test_select_i, standby_select: standby_select_i,
                       dt: output_double_term_select_i, fmt: format_select_i};

  sync2 #(.W($bits(pin_t))) u_pin_sync (
    .clk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .d_i(pin_raw_w),
    .q_o(pin_s)
  );

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_q;
  logic ctrl_sel_w;
  logic status_sel_w;
  logic [DATA_W-1:0] status_w;
  logic [DATA_W-1:0] rd_mux_w;
  logic pattern_w;

  assign ctrl_sel_w = (reg_addr_i == CTRL_OFS);
  assign status_sel_w = (reg_addr_i == STATUS_OFS);
  // Software can force the test word too; the pin alone is enough to enable it.
  assign pattern_w = pin_s.pattern | ctrl_q[CTRL_PATTERN_BIT];

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_wr_i && ctrl_sel_w) begin
      ctrl_q <= {31'h0000_0000, reg_wdata_i[CTRL_PATTERN_BIT]};
    end
  end

  // ----------------------------------------------------------------
  // Standby sequencing
  // ----------------------------------------------------------------
  pwr_state_t state_q;
  pwr_state_t state_d;
  logic [WAKE_CNT_W-1:0] wake_cnt_q;
  logic [WAKE_CNT_W-1:0] wake_cnt_d;

  assign standby_select_fall_w = standby_select_prev_q && !pin_s.standby_select;

  always_comb begin
    state_d = state_q;
    wake_cnt_d = wake_cnt_q;
    case (state_q)
      ST_RUN: begin
        if (pin_s.standby_select) begin
          state_d = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (standby_select_fall_w) begin
          state_d = ST_WAKE;
          wake_cnt_d = WAKE_LOAD;
        end
      end
      ST_WAKE: begin
        if (pin_s.standby_select) begin
          state_d = ST_STANDBY;
        end else if (wake_cnt_q == WAKE_ZERO) begin
          state_d = ST_RUN;
        end else begin
          wake_cnt_d = wake_cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = ST_STANDBY;
      end
    endcase
  end

  // Power-up is treated like a wake: the first words after reset are flagged invalid.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_WAKE;
      wake_cnt_q <= WAKE_LOAD;
      standby_select_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wake_cnt_q <= wake_cnt_d;
      standby_select_prev_q <= pin_s.standby_select;
    end
  end

  // ----------------------------------------------------------------
  // Registered control outputs and read data
  // ----------------------------------------------------------------
  logic pd_d;
  logic valid_d;

  assign pd_d = (state_d == ST_STANDBY);
  assign valid_d = (state_d == ST_RUN);
  assign status_w = {24'h00_0000, pattern_w, pin_s.fmt, pin_s.dt, pin_s.standby_select,
                     data_valid_o, channel_power_down_o, state_q};
  assign rd_mux_w = ctrl_sel_w ? ctrl_q : status_sel_w ? status_w : '0;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      channel_power_down_o <= 1'b0;
      input_disconnect_o <= 1'b0;
      ref_active_o <= 1'b1;
      term_enable_o <= 1'b0;
      data_valid_o <= 1'b0;
      reg_rdata_o <= '0;
    end else begin
      channel_power_down_o <= pd_d;
      input_disconnect_o <= pd_d;
      ref_active_o <= 1'b1;
      term_enable_o <= pin_s.dt;
      data_valid_o <= valid_d;
      reg_rdata_o <= reg_rd_i ? rd_mux_w : '0;
    end
  end

  // ----------------------------------------------------------------
  // Crossing to the link clock
  // ----------------------------------------------------------------
  // All three are slow levels, so a per-bit synchroniser is enough; a one-cycle
  // skew between them at a mode change only corrupts the word already in flight.
  link_ctrl_t link_src_q;
  link_ctrl_t link_s;
  logic [NUM_CH-1:0] ser_w;
  logic frame_w;
  logic bclk_w;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_src_q <= '0;
    end else begin
      link_src_q <= '{pattern: pattern_w, offset_bin: pin_s.fmt, run: !pd_d};
    end
  end

  sync2 #(.W($bits(link_ctrl_t))) u_link_sync (
    .clk_i(link_clk_i),
    .rst_b_i(rst_b_i),
    .d_i(link_src_q),
    .q_o(link_s)
  );

  adc_serializer u_ser (
    .link_clk_i(link_clk_i),
    .rst_b_i(rst_b_i),
    .ctrl_i(link_s),
    .conv_data_i(conv_data_i),
    .serial_q_o(ser_w),
    .frame_q_o(frame_w),
    .bclk_q_o(bclk_w)
  );

  // The complement legs come from their own flops so every pin is a register output.
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_data_pos_o <= '0;
      serial_data_neg_o <= '1;
      frame_align_out_pos_o <= 1'b0;
      frame_align_out_neg_o <= 1'b1;
      serial_bit_clock_pos_o <= 1'b0;
      serial_bit_clock_neg_o <= 1'b1;
    end else begin
      serial_data_pos_o <= ser_w;
      serial_data_neg_o <= ~ser_w;
      frame_align_out_pos_o <= frame_w;
      frame_align_out_neg_o <= ~frame_w;
      serial_bit_clock_pos_o <= bclk_w;
      serial_bit_clock_neg_o <= ~bclk_w;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  standby_power_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(pin_s.standby_select) && state_q == ST_RUN |=> ##1 channel_power_down_o && !data_valid_o)
    else $error("Standby request did not power down the channels.");

  input_cut_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state_q == ST_STANDBY |-> input_disconnect_o && channel_power_down_o)
    else $error("Analog inputs connected during standby.");

  ref_alive_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    channel_power_down_o |-> ref_active_o)
    else $error("Reference dropped during standby.");

  exit_fall_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state_q == ST_STANDBY && !standby_select_fall_w |=> state_q == ST_STANDBY)
    else $error("Standby left without a falling edge.");

  wake_settle_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(data_valid_o) |-> $past(state_q) == ST_WAKE && $past(wake_cnt_q) == WAKE_ZERO)
    else $error("Data valid before settle count expired.");

  wake_start_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $fell(channel_power_down_o) |-> !data_valid_o [*8])
    else $error("Data valid right after standby exit.");

  term_follow_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(output_double_term_select_i) ##1 output_double_term_select_i [*3] |=> term_enable_o)
    else $error("Termination did not follow its select.");

  read_data_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("Read data outside the read answer cycle.");

endmodule

//--- include/adc_ctl_pkg.sv
// Shared constants and types for the converter standby and test word logic.
package adc_ctl_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int WORD_W = 12;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Link framing, one bit per link clock cycle
  // ----------------------------------------------------------------
  localparam logic [3:0] BITS_PER_WORD = 4'hC;
  localparam logic [3:0] LAST_SLOT = 4'hB;
  localparam logic [3:0] CAPTURE_SLOT = 4'h0;
  // Half a word period after the capture slot, giving the half cycle of latency.
  localparam logic [3:0] LOAD_SLOT = 4'h6;
  // Whole conversion periods of latency, plus the capture stage itself.
  localparam int PIPE_DEPTH = 7;
  localparam logic [WORD_W-1:0] TEST_WORD = 12'h0BD;
  localparam int MSB = WORD_W - 1;

  // ----------------------------------------------------------------
  // Wake-up timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int WAKE_TIME_NS = 200000;
  localparam int WAKE_CYCLES_DEF = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W = 15;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam int CTRL_PATTERN_BIT = 0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {ST_RUN, ST_STANDBY, ST_WAKE} pwr_state_t;

  typedef struct packed {
    logic pattern;
    logic standby_select;
    logic dt;
    logic fmt;
  } pin_t;

  typedef struct packed {
    logic pattern;
    logic offset_bin;
    logic run;
  } link_ctrl_t;

  typedef logic [NUM_CH-1:0][WORD_W-1:0] conv_bus_t;

endpackage

//--- verilog/sync2.sv
// Two flip-flop level synchroniser.
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

//--- verilog/adc_serializer.sv
// Link-side word pipeline, test word insertion and LSB-first serialiser.
`timescale 1ns/1ns
module adc_serializer
  import adc_ctl_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic rst_b_i,
  input wire link_ctrl_t ctrl_i,
  input wire conv_bus_t conv_data_i,
  output logic [NUM_CH-1:0] serial_q_o,
  output logic frame_q_o,
  output logic bclk_q_o
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic cap_w;
  logic load_w;
  logic frame_d;
  logic [3:0] run_len_q;
  logic [3:0] run_len_d;
  logic [WORD_W-1:0] pipe_q [NUM_CH][PIPE_DEPTH];
  logic [WORD_W-1:0] word_w [NUM_CH];
  logic [WORD_W-1:0] shreg_q [NUM_CH];

  // ----------------------------------------------------------------
  // Slot counter
  // ----------------------------------------------------------------
  // Powered-down channels park the counter so the first word after wake is whole.
  assign cnt_d = !ctrl_i.run ? CAPTURE_SLOT : (cnt_q == LAST_SLOT) ? CAPTURE_SLOT : cnt_q + 4'h1;
  assign cap_w = ctrl_i.run && (cnt_q == CAPTURE_SLOT);
  assign load_w = ctrl_i.run && (cnt_q == LOAD_SLOT);
  assign frame_d = ctrl_i.run && (cnt_q >= LOAD_SLOT);
  // Saturating count of consecutive running cycles, read only by the frame period check.
  assign run_len_d = !ctrl_i.run ? '0 : (&run_len_q) ? run_len_q : run_len_q + 4'h1;

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 4'h0;
      run_len_q <= 4'h0;
      frame_q_o <= 1'b0;
      bclk_q_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_len_q <= run_len_d;
      frame_q_o <= frame_d;
      bclk_q_o <= ctrl_i.run ? ~bclk_q_o : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel pipeline and shifter
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign word_w[c] = ctrl_i.pattern ? TEST_WORD : pipe_q[c][PIPE_DEPTH-1];

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        for (int s = 0; s < PIPE_DEPTH; s++) begin
          pipe_q[c][s] <= '0;
        end
      end else if (cap_w) begin
        // Core words are two's complement; offset binary flips the sign bit.
        pipe_q[c][0] <= {conv_data_i[c][MSB] ^ ctrl_i.offset_bin, conv_data_i[c][MSB-1:0]};
        for (int s = 1; s < PIPE_DEPTH; s++) begin
          pipe_q[c][s] <= pipe_q[c][s-1];
        end
      end
    end

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        shreg_q[c] <= '0;
        serial_q_o[c] <= 1'b0;
      end else if (!ctrl_i.run) begin
        shreg_q[c] <= '0;
        serial_q_o[c] <= 1'b0;
      end else if (load_w) begin
        shreg_q[c] <= {1'b0, word_w[c][MSB:1]};
        serial_q_o[c] <= word_w[c][0];
      end else begin
        shreg_q[c] <= {1'b0, shreg_q[c][MSB:1]};
        serial_q_o[c] <= shreg_q[c][0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  frame_rise_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    $rose(frame_q_o) |-> $past(cnt_q) == LOAD_SLOT)
    else $error("Frame rose away from the first bit slot.");

  frame_period_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    $rose(frame_q_o) |-> ##12 ($rose(frame_q_o) || run_len_q < BITS_PER_WORD))
    else $error("Frame did not repeat after twelve bits.");

  test_word_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    (load_w && ctrl_i.pattern) ##1 ctrl_i.run [*3] |=>
      $past(serial_q_o[0], 3) == TEST_WORD[0] && $past(serial_q_o[0], 2) == TEST_WORD[1]
      && $past(serial_q_o[0], 1) == TEST_WORD[2] && serial_q_o[0] == TEST_WORD[3])
    else $error("Test word bits out of order.");

  normal_word_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    (load_w && !ctrl_i.pattern) |=> serial_q_o[0] == $past(pipe_q[0][PIPE_DEPTH-1][0]))
    else $error("Conversion word not sent LSB first.");

  bit_clock_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    ctrl_i.run && $past(ctrl_i.run) |-> bclk_q_o != $past(bclk_q_o))
    else $error("Bit clock missed a toggle.");

  format_msb_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    cap_w |=> pipe_q[0][0][MSB] == ($past(conv_data_i[0][MSB]) ^ $past(ctrl_i.offset_bin)))
    else $error("Output format sign bit wrong.");

endmodule

//--- sim/rx_model.sv
// Behavioural serial receiver that rebuilds words from the link outputs.
`timescale 1ns/1ns
module rx_model
  import adc_ctl_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic rst_b_i,
  input wire logic valid_i,
  input wire logic [NUM_CH-1:0] data_pos_i,
  input wire logic [NUM_CH-1:0] data_neg_i,
  input wire logic frame_pos_i,
  input wire logic frame_neg_i,
  input wire logic bclk_pos_i,
  input wire logic bclk_neg_i,
  output conv_bus_t word_o,
  output logic [15:0] words_o,
  output logic [15:0] err_o
);
  // ------------------------------
  // Capture
  // ------------------------------
  // Sampling on the falling edge keeps clear of the transmitter's launch edge.
  logic [3:0] idx_q;
  logic [3:0] per_q;
  logic frame_prev_q;
  logic bclk_prev_q;
  logic live_q;
  logic bad;
  logic toggling;
  conv_bus_t shift_q;
  always @(negedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idx_q <= 4'hC;
      per_q <= 4'h0;
      frame_prev_q <= 1'b0;
      bclk_prev_q <= 1'b0;
      live_q <= 1'b0;
      shift_q <= '0;
      word_o <= '0;
      words_o <= 16'h0000;
      err_o <= 16'h0000;
    end else begin
      toggling = (bclk_pos_i !== bclk_prev_q);
      frame_prev_q <= frame_pos_i;
      bclk_prev_q <= bclk_pos_i;
      per_q <= (per_q == 4'hF) ? per_q : per_q + 4'h1;
      bad = (data_neg_i !== ~data_pos_i) || (frame_neg_i !== ~frame_pos_i) || (bclk_neg_i !== ~bclk_pos_i);
      if (frame_pos_i === 1'b1 && frame_prev_q === 1'b0) begin
        bad = bad || (bclk_pos_i !== 1'b1) || (live_q && per_q != 4'hC);
        live_q <= 1'b1;
        per_q <= 4'h1;
        idx_q <= 4'h1;
        for (int c = 0; c < NUM_CH; c++) shift_q[c][0] <= data_pos_i[c];
      end else if (idx_q < 4'hC) begin
        // A word cut short by standby ends early; the link is invalid by then, so skip it.
        bad = bad || (valid_i === 1'b1 && toggling && (frame_pos_i !== (idx_q < 4'h6)));
        idx_q <= idx_q + 4'h1;
        for (int c = 0; c < NUM_CH; c++) shift_q[c][idx_q] <= data_pos_i[c];
        if (idx_q == 4'hB) begin
          for (int c = 0; c < NUM_CH; c++) word_o[c] <= {data_pos_i[c], shift_q[c][10:0]};
          // Words during the settle time are discarded as invalid.
          if (valid_i === 1'b1) words_o <= words_o + 16'h0001;
        end
      end
      if (!toggling) live_q <= 1'b0;
      if (bad) err_o <= err_o + 16'h0001;
    end
  end
endmodule

//--- sim/testbench.sv
// Self-checking testbench for the standby, test word and link logic.
`timescale 1ns/1ns
module testbench;
  import adc_ctl_pkg::*;
  localparam int WAKE_SIM = 20;
  logic mclk_i, link_clk_i, rst_b_i, pattern_i, standby_i, dt_i, fmt_i, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  conv_bus_t conv, rx_word;
  logic [NUM_CH-1:0] sd_pos, sd_neg;
  logic fr_pos, fr_neg, bc_pos, bc_neg, pwr_dn, in_disc, ref_on, term_on, valid;
  logic [15:0] words, rx_err;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  adc_standby_ctl #(.WAKE_CYCLES(WAKE_SIM)) uut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk_i), .pattern_test_select_i(pattern_i),
    .standby_select_i(standby_i), .output_double_term_select_i(dt_i), .format_select_i(fmt_i),
    .conv_data_i(conv), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .serial_data_pos_o(sd_pos), .serial_data_neg_o(sd_neg),
    .frame_align_out_pos_o(fr_pos), .frame_align_out_neg_o(fr_neg), .serial_bit_clock_pos_o(bc_pos),
    .serial_bit_clock_neg_o(bc_neg), .channel_power_down_o(pwr_dn), .input_disconnect_o(in_disc),
    .ref_active_o(ref_on), .term_enable_o(term_on), .data_valid_o(valid));

  rx_model rx (.link_clk_i(link_clk_i), .rst_b_i(rst_b_i), .valid_i(valid), .data_pos_i(sd_pos),
    .data_neg_i(sd_neg), .frame_pos_i(fr_pos), .frame_neg_i(fr_neg), .bclk_pos_i(bc_pos),
    .bclk_neg_i(bc_neg), .word_o(rx_word), .words_o(words), .err_o(rx_err));

  // ------------------------------
  // Clocks and watchdog
  // ------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #15 link_clk_i = ~link_clk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      $display("Error at %0t: run did not finish", $time);
      conclude();
    end
  end

  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    chk({31'h0, got}, {31'h0, exp}, what);
  endtask
  function automatic logic [11:0] cval(input int c, input logic [11:0] base, input logic [11:0] step);
    return base + 12'(c) * step;
  endfunction
  task automatic set_conv(input logic [11:0] base);
    for (int c = 0; c < NUM_CH; c++) conv[c] <= cval(c, base, 12'h231);
  endtask
  task automatic chk_words(input logic [11:0] base, input logic [11:0] step, input logic [11:0] flip);
    for (int c = 0; c < NUM_CH; c++) chk({20'h0, rx_word[c]}, {20'h0, cval(c, base, step) ^ flip}, "word");
  endtask
  task automatic wait_words(input int n);
    int k;
    logic [15:0] w0;
    k = 0;
    w0 = words;
    while (int'(words - w0) < n && k < 600) begin
      @(posedge link_clk_i);
      k++;
    end
    if (k >= 600) chk(32'h0, 32'h1, "word stream stalled");
  endtask
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk_i);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk_i);
    reg_rd <= 1'b0;
    @(negedge mclk_i);
    d = reg_rdata;
  endtask
  task automatic wait_valid(output int n);
    n = 0;
    while (valid !== 1'b1 && n < 200) begin
      @(posedge mclk_i);
      n++;
    end
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_power_up;
    logic [31:0] d;
    int n;
    chk1(ref_on, 1'b1, "reference on");
    chk1(valid, 1'b0, "valid at start");
    wait_valid(n);
    chk1(n >= WAKE_SIM && n <= WAKE_SIM + 8, 1'b1, "settle length");
    reg_write(4'hC, 32'hFFFF_FFFF);
    reg_read(CTRL_OFS, d);
    chk(d, CTRL_RESET, "control after unmapped write");
    reg_read(4'h8, d);
    chk(d, 32'h0, "unmapped read");
    reg_read(STATUS_OFS, d);
    chk({24'h0, d[7:0]}, 32'h08, "status in run");
  endtask
  task automatic t_latency;
    logic [15:0] w0;
    int n;
    set_conv(12'h3A5);
    wait_words(10);
    // Changing just after a word lands fixes the phase to the capture slot.
    set_conv(12'h5C3);
    w0 = words;
    n = 0;
    while (rx_word[0] !== 12'h5C3 && n < 200) begin
      @(posedge link_clk_i);
      n++;
    end
    chk({16'h0, words - w0}, 32'h8, "words until new sample");
  endtask
  task automatic t_format;
    set_conv(12'h000);
    wait_words(10);
    chk_words(12'h000, 12'h231, 12'h000);
    @(posedge mclk_i);
    fmt_i <= 1'b1;
    wait_words(10);
    chk_words(12'h000, 12'h231, 12'h800);
  endtask
  task automatic t_pattern;
    logic [31:0] d;
    @(posedge mclk_i);
    pattern_i <= 1'b1;
    wait_words(3);
    chk_words(12'h0BD, 12'h000, 12'h000);
    wait_words(1);
    chk_words(12'h0BD, 12'h000, 12'h000);
    @(posedge mclk_i);
    pattern_i <= 1'b0;
    wait_words(3);
    chk_words(12'h000, 12'h231, 12'h800);
    reg_write(CTRL_OFS, 32'h1);
    wait_words(3);
    chk_words(12'h0BD, 12'h000, 12'h000);
    reg_read(CTRL_OFS, d);
    chk(d, 32'h1, "control readback");
    reg_write(CTRL_OFS, 32'h0);
  endtask
  task automatic t_standby;
    logic [31:0] d;
    int n;
    @(posedge mclk_i);
    standby_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk1(pwr_dn, 1'b1, "power down");
    chk1(in_disc, 1'b1, "inputs cut off");
    chk1(ref_on, 1'b1, "reference in standby");
    chk1(valid, 1'b0, "valid in standby");
    repeat (30) @(posedge link_clk_i);
    chk1(fr_pos, 1'b0, "frame parked");
    chk1(pwr_dn, 1'b1, "standby held");
    reg_read(STATUS_OFS, d);
    chk({29'h0, d[2:0]}, 32'h5, "status in standby");
    @(posedge mclk_i);
    standby_i <= 1'b0;
    wait_valid(n);
    chk1(n >= WAKE_SIM && n <= WAKE_SIM + 8, 1'b1, "wake settle");
    chk1(pwr_dn | in_disc, 1'b0, "awake");
    wait_words(10);
    chk_words(12'h000, 12'h231, 12'h800);
  endtask
  task automatic t_term;
    @(posedge mclk_i);
    dt_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    chk1(term_on, 1'b1, "termination on");
    dt_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    chk1(term_on, 1'b0, "termination off");
  endtask

  initial begin
    rst_b_i = 1'b1;
    pattern_i = 1'b0;
    standby_i = 1'b0;
    dt_i = 1'b0;
    fmt_i = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    conv = '0;
    // The link side sees no clock edge during reset, so it needs a clean falling edge.
    #1 rst_b_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_power_up();
    t_latency();
    t_format();
    t_pattern();
    t_standby();
    t_term();
    chk({16'h0, rx_err}, 32'h0, "receiver framing");
    conclude();
  end
endmodule
